// [design/radio_pwr_consts.svh]
`ifndef RADIO_PWR_CONSTS_SVH
`define RADIO_PWR_CONSTS_SVH

// core clock period
`define CLK_PERIOD_NS      8

// indicative transition times, as printed, in ns
`define T_FROM_SHUTDOWN_NS 15000000
`define T_FROM_STANDBY_NS  440000
`define T_FROM_SPI_NS      340000
`define T_FROM_READY_NS    100000
`define T_TXTUNE_TX_NS     58000
`define T_RXTUNE_RX_NS     60000
`define T_TURNAROUND_NS    75000
`define T_TURN_ZERO_IF_NS  70000
`define T_SDN_HIGH_MIN_NS  10000

// derived cycle counts; the printed figures divide evenly by the period
`define CYC_FROM_SHUTDOWN  (`T_FROM_SHUTDOWN_NS / `CLK_PERIOD_NS)
`define CYC_FROM_STANDBY   (`T_FROM_STANDBY_NS / `CLK_PERIOD_NS)
`define CYC_FROM_SPI       (`T_FROM_SPI_NS / `CLK_PERIOD_NS)
`define CYC_FROM_READY     (`T_FROM_READY_NS / `CLK_PERIOD_NS)
`define CYC_TXTUNE_TX      (`T_TXTUNE_TX_NS / `CLK_PERIOD_NS)
`define CYC_RXTUNE_RX      (`T_RXTUNE_RX_NS / `CLK_PERIOD_NS)
`define CYC_TURNAROUND     (`T_TURNAROUND_NS / `CLK_PERIOD_NS)
`define CYC_TURN_ZERO_IF   (`T_TURN_ZERO_IF_NS / `CLK_PERIOD_NS)
`define CYC_SDN_HIGH_MIN   (`T_SDN_HIGH_MIN_NS / `CLK_PERIOD_NS)

// timer width, fits the longest count
`define SEQ_TIMER_W        21

`endif

// [design/radio_pwr_pkg.sv]
package radio_pwr_pkg;

   typedef enum logic [3:0] {
      ST_SHUTDOWN,
      ST_POR,
      ST_STANDBY,
      ST_SLEEP,
      ST_SPI_ACTIVE,
      ST_READY,
      ST_TX_TUNE,
      ST_RX_TUNE,
      ST_TX,
      ST_RX
   } op_state_t;

   typedef enum logic [1:0] {
      CMD_BOOT,
      CMD_START_RX,
      CMD_START_TX,
      CMD_CHANGE_STATE
   } cmd_t;

   typedef struct packed {
      op_state_t st;
      op_state_t origin;
      op_state_t target;
      op_state_t next_st;
      logic      booted;
      logic      sel_q;
      logic      refused;
      logic      irq_pend;
   } ctl_t;

endpackage

// [design/seq_timer.sv]
`timescale 1ns/1ns
`include "radio_pwr_consts.svh"

module seq_timer
   import radio_pwr_pkg::*;
#(
   parameter int unsigned TW = `SEQ_TIMER_W
) (
   input  wire logic          core_clk_i,
   input  wire logic          rst_n_i,
   input  wire logic          clr_i,
   input  wire logic          load_i,
   input  wire logic [TW-1:0] load_val_i,
   output logic               busy_o,
   output logic               done_o
);

   typedef struct packed {
      logic [TW-1:0] cnt;
   } tmr_t;

   tmr_t tmr_reg;
   tmr_t tmr_next;

   // load wins over counting, clear wins over both
   always_comb begin
      tmr_next = tmr_reg;
      if (clr_i) begin
         tmr_next.cnt = '0;
      end else if (load_i) begin
         tmr_next.cnt = load_val_i;
      end else if (tmr_reg.cnt != '0) begin
         tmr_next.cnt = tmr_reg.cnt - TW'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tmr_reg <= '0;
      end else begin
         tmr_reg <= tmr_next;
      end
   end

   // done marks the last counted cycle, so the owner switches exactly on time;
   // load stays out of it, the owner never loads while busy and would loop back
   assign busy_o = (tmr_reg.cnt != '0);
   assign done_o = (tmr_reg.cnt == TW'(1)) && !clr_i;

   property p_load_runs;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (rst_n_i && load_i && !clr_i && load_val_i > TW'(1)) |=> busy_o ##1 busy_o;
   endproperty
   a_load_runs: assert property (p_load_runs)
      else $error("timer not busy after a load");

endmodule // seq_timer

// [design/radio_power_state_control.sv]
`timescale 1ns/1ns
`include "radio_pwr_consts.svh"

// How it works
// - only rx, tx and state-change commands move state; shutdown pin alone
// - sequencer reaches rx or tx from any state by itself
// - after rx or tx completes, return to configured lower-power state
// - transition time counted from select rise; 15 ms, 440, 340, 100 us
// - tx-tune to tx about 58 us, rx-tune to rx about 60 us
// - tx to rx either way about 75 us, 70 us in zero-IF
// - begin rx and begin tx carry a following-state selection
// - shutdown pin high forces shutdown; host keeps it low otherwise
// - in shutdown all contents lost and serial interface ignored
// - releasing shutdown starts power-on reset and calibration
// - standby keeps register contents, everything else disabled
// - serial event in standby starts boot oscillator, enters serial-active
// - pending interrupt must be read to reach minimum consumption
// - sleep is standby plus wake-up timer on a 32 kHz clock
// - serial event in sleep starts boot oscillator, enters serial-active
// - serial-active never falls back alone; waits for state-change
// - while sequencing, clear-to-send low and commands refused; in ST_POR and the last busy cycle a command is dropped without cmd_refused_o
module radio_power_state_control
   import radio_pwr_pkg::*;
#(
   parameter int unsigned TW          = `SEQ_TIMER_W,
   parameter int unsigned POR_CYC     = `CYC_FROM_SHUTDOWN,
   parameter int unsigned STANDBY_CYC = `CYC_FROM_STANDBY,
   parameter int unsigned SPI_CYC     = `CYC_FROM_SPI,
   parameter int unsigned READY_CYC   = `CYC_FROM_READY,
   parameter int unsigned TXTUNE_CYC  = `CYC_TXTUNE_TX,
   parameter int unsigned RXTUNE_CYC  = `CYC_RXTUNE_RX,
   parameter int unsigned TURN_CYC    = `CYC_TURNAROUND,
   parameter int unsigned ZIF_CYC     = `CYC_TURN_ZERO_IF
) (
   input  wire logic      core_clk_i,
   input  wire logic      rst_n_i,
   input  wire logic      shutdown_pin_i,
   input  wire logic      serial_select_n_i,
   input  wire logic      cmd_valid_i,
   input  wire cmd_t      cmd_code_i,
   input  wire op_state_t cmd_target_i,
   input  wire op_state_t cmd_next_i,
   input  wire logic      zero_if_i,
   input  wire logic      op_done_i,
   input  wire logic      irq_event_i,
   input  wire logic      int_status_read_i,
   output op_state_t      state_o,
   output logic           cts_o,
   output logic           cmd_refused_o,
   output logic           booted_o,
   output logic           interrupt_out_n_o,
   output logic           boot_osc_en_o,
   output logic           wakeup_timer_en_o,
   output logic           xtal_osc_en_o,
   output logic           regs_retained_o,
   output logic           min_current_o
);

   ctl_t          ctl_reg;
   ctl_t          ctl_next;
   logic          t_load;
   logic [TW-1:0] t_load_val;
   logic          t_busy;
   logic          t_done;
   logic          sel_fall;
   op_state_t     eff_origin;
   logic          running;

   // states that a state-change may name; a following-state must also pass is_low
   function automatic logic is_target(input op_state_t s);
      is_target = (s != ST_SHUTDOWN) && (s != ST_POR);
   endfunction

   function automatic logic is_low(input op_state_t s);
      is_low = (s == ST_STANDBY) || (s == ST_SLEEP) || (s == ST_SPI_ACTIVE) ||
               (s == ST_READY) || (s == ST_TX_TUNE) || (s == ST_RX_TUNE);
   endfunction

   // travel time from origin to target; moves downward take one cycle
   function automatic logic [TW-1:0] trans_cyc(input op_state_t org,
                                               input op_state_t tgt,
                                               input logic      zif);
      logic radio_up;
      radio_up = (tgt == ST_TX) || (tgt == ST_RX) ||
                 (tgt == ST_TX_TUNE) || (tgt == ST_RX_TUNE);
      trans_cyc = TW'(1);
      if (radio_up) begin
         unique case (org)
            ST_STANDBY, ST_SLEEP: trans_cyc = TW'(STANDBY_CYC);
            ST_SPI_ACTIVE:        trans_cyc = TW'(SPI_CYC);
            ST_READY:             trans_cyc = TW'(READY_CYC);
            ST_TX_TUNE: trans_cyc = (tgt == ST_TX) ? TW'(TXTUNE_CYC) : TW'(READY_CYC);
            ST_RX_TUNE: trans_cyc = (tgt == ST_RX) ? TW'(RXTUNE_CYC) : TW'(READY_CYC);
            ST_TX: trans_cyc = (tgt == ST_RX) ? (zif ? TW'(ZIF_CYC) : TW'(TURN_CYC))
                                              : TW'(1);
            ST_RX: trans_cyc = (tgt == ST_TX) ? (zif ? TW'(ZIF_CYC) : TW'(TURN_CYC))
                                              : TW'(1);
            ST_SHUTDOWN, ST_POR: trans_cyc = TW'(POR_CYC);
         endcase
      end
   endfunction

   seq_timer #(
      .TW (TW)
   ) u_timer (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .clr_i      (shutdown_pin_i),
      .load_i     (t_load),
      .load_val_i (t_load_val),
      .busy_o     (t_busy),
      .done_o     (t_done)
   );

   // a transaction that woke the part is timed from the state it woke from
   assign sel_fall   = ctl_reg.sel_q && !serial_select_n_i;
   assign eff_origin = (ctl_reg.st == ST_SPI_ACTIVE) ? ctl_reg.origin : ctl_reg.st;
   assign running    = (ctl_reg.st != ST_SHUTDOWN) && (ctl_reg.st != ST_POR);

   // next-state logic for the whole controller
   always_comb begin
      ctl_next         = ctl_reg;
      ctl_next.refused = 1'b0;
      ctl_next.sel_q   = serial_select_n_i;
      t_load           = 1'b0;
      t_load_val       = TW'(1);
      // status read clears, a new event in the same cycle wins
      ctl_next.irq_pend = irq_event_i || (ctl_reg.irq_pend && !int_status_read_i);
      if (shutdown_pin_i) begin
         ctl_next       = '0;
         ctl_next.st    = ST_SHUTDOWN;
         ctl_next.sel_q = serial_select_n_i;
      end else begin
         unique case (ctl_reg.st)
            ST_SHUTDOWN: begin
               ctl_next.st = ST_POR;
               t_load      = 1'b1;
               t_load_val  = TW'(POR_CYC);
            end
            ST_POR: begin
               ctl_next.irq_pend = 1'b0;
               if (t_done) begin
                  ctl_next.st = ST_STANDBY;
               end
            end
            ST_STANDBY, ST_SLEEP, ST_SPI_ACTIVE, ST_READY,
            ST_TX_TUNE, ST_RX_TUNE, ST_TX, ST_RX: begin
               if (t_done) begin
                  ctl_next.st = ctl_reg.target;
               end else if (t_busy) begin
                  ctl_next.refused = cmd_valid_i;
               end else begin
                  if (sel_fall) begin
                     ctl_next.origin = ctl_reg.st;
                     if ((ctl_reg.st == ST_STANDBY) || (ctl_reg.st == ST_SLEEP)) begin
                        ctl_next.st = ST_SPI_ACTIVE;
                     end
                  end
                  if (op_done_i && ((ctl_reg.st == ST_TX) || (ctl_reg.st == ST_RX))) begin
                     ctl_next.st = ctl_reg.next_st;
                  end
                  if (cmd_valid_i) begin
                     unique case (cmd_code_i)
                        CMD_BOOT: begin
                           ctl_next.booted = 1'b1;
                        end
                        CMD_START_TX, CMD_START_RX: begin
                           if (ctl_reg.booted) begin
                              ctl_next.target = (cmd_code_i == CMD_START_TX) ? ST_TX : ST_RX;
                              if (is_low(cmd_next_i)) begin
                                 ctl_next.next_st = cmd_next_i;
                              end
                              t_load     = 1'b1;
                              t_load_val = trans_cyc(eff_origin, ctl_next.target, zero_if_i);
                           end else begin
                              ctl_next.refused = 1'b1;
                           end
                        end
                        CMD_CHANGE_STATE: begin
                           if (ctl_reg.booted && is_target(cmd_target_i)) begin
                              ctl_next.target = cmd_target_i;
                              t_load          = 1'b1;
                              t_load_val = trans_cyc(eff_origin, cmd_target_i, zero_if_i);
                           end else begin
                              ctl_next.refused = 1'b1;
                           end
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // one register for all control state
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ctl_reg         <= '0;
         ctl_reg.st      <= ST_SHUTDOWN;
         ctl_reg.next_st <= ST_READY;
         ctl_reg.sel_q   <= 1'b1;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // outputs; power enables follow the state, and the crystal also runs while the timer is busy
   assign state_o           = ctl_reg.st;
   assign cts_o             = running && !t_busy && !shutdown_pin_i;
   assign cmd_refused_o     = ctl_reg.refused;
   assign booted_o          = ctl_reg.booted;
   assign interrupt_out_n_o = !ctl_reg.irq_pend;
   assign boot_osc_en_o     = (ctl_reg.st == ST_SPI_ACTIVE) || (ctl_reg.st == ST_POR);
   assign wakeup_timer_en_o = (ctl_reg.st == ST_SLEEP);
   assign xtal_osc_en_o     = t_busy || ((ctl_reg.st != ST_SHUTDOWN) &&
                              (ctl_reg.st != ST_POR) && (ctl_reg.st != ST_STANDBY) &&
                              (ctl_reg.st != ST_SLEEP) && (ctl_reg.st != ST_SPI_ACTIVE));
   // contents held in every state but shutdown
   assign regs_retained_o   = (ctl_reg.st != ST_SHUTDOWN);
   assign min_current_o     = ((ctl_reg.st == ST_STANDBY) || (ctl_reg.st == ST_SLEEP)) &&
                              !ctl_reg.irq_pend && !t_busy;

   sequence s_quiet;
      !cmd_valid_i && !sel_fall && !op_done_i && !shutdown_pin_i && !t_busy;
   endsequence

   sequence s_wake(op_state_t s);
      ctl_reg.st == s && !t_busy && sel_fall && !shutdown_pin_i && !cmd_valid_i;
   endsequence

   property p_shutdown_enter;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      shutdown_pin_i |=> state_o == ST_SHUTDOWN && !booted_o && interrupt_out_n_o;
   endproperty
   a_shutdown_enter: assert property (p_shutdown_enter)
      else $error("shutdown pin did not force shutdown");

   property p_shutdown_deaf;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (shutdown_pin_i && cmd_valid_i) |=> !cts_o && !cmd_refused_o && !regs_retained_o;
   endproperty
   a_shutdown_deaf: assert property (p_shutdown_deaf)
      else $error("serial activity seen in shutdown");

   property p_release_por;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (rst_n_i && state_o == ST_SHUTDOWN && !shutdown_pin_i) ##1 !shutdown_pin_i
         |-> state_o == ST_POR && t_busy && !cts_o;
   endproperty
   a_release_por: assert property (p_release_por)
      else $error("power-on reset not started on release");

   property p_standby_wake;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_wake(ST_STANDBY) |=> state_o == ST_SPI_ACTIVE && boot_osc_en_o;
   endproperty
   a_standby_wake: assert property (p_standby_wake)
      else $error("standby did not wake on serial event");

   property p_sleep_wake;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_wake(ST_SLEEP) |=> state_o == ST_SPI_ACTIVE && !wakeup_timer_en_o;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake)
      else $error("sleep did not wake on serial event");

   property p_spi_holds;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      ((state_o == ST_SPI_ACTIVE) and s_quiet) ##1 s_quiet |-> state_o == ST_SPI_ACTIVE;
   endproperty
   a_spi_holds: assert property (p_spi_holds)
      else $error("serial-active left without a command");

   property p_idle_holds;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (running and s_quiet) |=> state_o == $past(state_o);
   endproperty
   a_idle_holds: assert property (p_idle_holds)
      else $error("state moved with nothing pending");

   property p_busy_refuse;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (t_busy && cmd_valid_i && !t_done && running && !shutdown_pin_i)
         |-> !cts_o ##1 cmd_refused_o && state_o == $past(state_o);
   endproperty
   a_busy_refuse: assert property (p_busy_refuse)
      else $error("command taken during a transition");

   property p_auto_return;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_o == ST_TX && op_done_i && !t_busy && !cmd_valid_i && !shutdown_pin_i)
         |=> state_o == $past(ctl_reg.next_st) && is_low(state_o);
   endproperty
   a_auto_return: assert property (p_auto_return)
      else $error("no automatic return after transmit");

   property p_start_tx;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_o == ST_READY && cmd_valid_i && cmd_code_i == CMD_START_TX && booted_o &&
       !t_busy && !shutdown_pin_i) |=> !cts_o ##1 t_busy && state_o == ST_READY;
   endproperty
   a_start_tx: assert property (p_start_tx)
      else $error("start transmit did not launch the sequencer");

endmodule // radio_power_state_control

// [verif/host_mcu_model.sv]
`timescale 1ns/1ns
`include "radio_pwr_consts.svh"

// host controller: select frames, decoded commands and the shutdown pin
module host_mcu_model
   import radio_pwr_pkg::*;
#(
   parameter int unsigned SDN_HOLD = `CYC_SDN_HIGH_MIN
) (
   input  wire logic core_clk_i,
   output logic      shutdown_pin_o,
   output logic      serial_select_n_o,
   output logic      cmd_valid_o,
   output cmd_t      cmd_code_o,
   output op_state_t cmd_target_o,
   output op_state_t cmd_next_o,
   output logic      int_status_read_o
);
   int unsigned sdn_cnt = 0;

   // pin actively driven
   // the pin comes from our own output and sits low outside shutdown
   initial begin
      shutdown_pin_o    = 1'b0;
      serial_select_n_o = 1'b1;
      cmd_valid_o       = 1'b0;
      cmd_code_o        = CMD_BOOT;
      cmd_target_o      = ST_READY;
      cmd_next_o        = ST_READY;
      int_status_read_o = 1'b0;
   end

   // high time of the shutdown pin, guards the release
   always @(posedge core_clk_i) begin
      sdn_cnt <= shutdown_pin_o ? sdn_cnt + 1 : 0;
   end

   // commands carry next state
   // one select frame; a command, if sent, rides on the select rise
   task automatic xact(input logic send, input cmd_t c, input op_state_t t,
                       input op_state_t n);
      @(posedge core_clk_i);
      serial_select_n_o <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      serial_select_n_o <= 1'b1;
      cmd_valid_o       <= send;
      cmd_code_o        <= c;
      cmd_target_o      <= t;
      cmd_next_o        <= n;
      @(posedge core_clk_i);
      cmd_valid_o       <= 1'b0;
      // stale fields are scrambled so nothing leans on the old command
      cmd_code_o        <= cmd_t'(~c);
      cmd_target_o      <= op_state_t'(~t);
      cmd_next_o        <= op_state_t'(~n);
   endtask

   task automatic read_status();
      @(posedge core_clk_i);
      int_status_read_o <= 1'b1;
      @(posedge core_clk_i);
      int_status_read_o <= 1'b0;
   endtask

   task automatic sdn_on();
      @(posedge core_clk_i);
      shutdown_pin_o <= 1'b1;
   endtask

   // minimum high time
   // a short pulse could leave the restart half done
   task automatic sdn_off();
      @(posedge core_clk_i);
      while (sdn_cnt < SDN_HOLD) @(posedge core_clk_i);
      shutdown_pin_o <= 1'b0;
   endtask
endmodule // host_mcu_model

// [verif/tb.sv]
`timescale 1ns/1ns

module tb;
   import radio_pwr_pkg::*;

   // short counts keep the run brief; expectations use the same values
   localparam int unsigned POR = 40;
   localparam int unsigned SBY = 20;
   localparam int unsigned SPI = 16;
   localparam int unsigned RDY = 12;
   localparam int unsigned TXT = 8;
   localparam int unsigned RXT = 9;
   localparam int unsigned TRN = 10;
   localparam int unsigned ZIF = 9;
   localparam int unsigned LIMIT = 6000;

   logic      core_clk_i  = 1'b0;
   logic      rst_n_i     = 1'b0;
   logic      zero_if_i   = 1'b0;
   logic      op_done_i   = 1'b0;
   logic      irq_event_i = 1'b0;
   logic      shutdown_pin, sel_n, cvalid, st_rd;
   cmd_t      ccode;
   op_state_t ctgt, cnext, state_o;
   logic      cts_o, refused_o, booted_o, irq_n_o, bosc_o;
   logic      wut_o, xosc_o, ret_o, minc_o;
   int        err_total  = 0;
   int        num_checks = 0;
   int        cyc        = 0;

   radio_power_state_control #(
      .POR_CYC(POR), .STANDBY_CYC(SBY), .SPI_CYC(SPI), .READY_CYC(RDY),
      .TXTUNE_CYC(TXT), .RXTUNE_CYC(RXT), .TURN_CYC(TRN), .ZIF_CYC(ZIF)
   ) dut (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .shutdown_pin_i(shutdown_pin),
      .serial_select_n_i(sel_n), .cmd_valid_i(cvalid), .cmd_code_i(ccode),
      .cmd_target_i(ctgt), .cmd_next_i(cnext), .zero_if_i(zero_if_i),
      .op_done_i(op_done_i), .irq_event_i(irq_event_i), .int_status_read_i(st_rd),
      .state_o(state_o), .cts_o(cts_o), .cmd_refused_o(refused_o),
      .booted_o(booted_o), .interrupt_out_n_o(irq_n_o), .boot_osc_en_o(bosc_o),
      .wakeup_timer_en_o(wut_o), .xtal_osc_en_o(xosc_o), .regs_retained_o(ret_o),
      .min_current_o(minc_o)
   );

   host_mcu_model host (
      .core_clk_i(core_clk_i), .shutdown_pin_o(shutdown_pin), .serial_select_n_o(sel_n),
      .cmd_valid_o(cvalid), .cmd_code_o(ccode), .cmd_target_o(ctgt),
      .cmd_next_o(cnext), .int_status_read_o(st_rd)
   );

   always #4 core_clk_i = ~core_clk_i;

   // hang guard, far beyond the planned sequence
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic chk_st(input string what, input op_state_t exp, input op_state_t got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk_num(input string what, input int unsigned exp, input int unsigned got);
      num_checks++;
      if (got != exp) begin
         err_total++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   // cycles until clear-to-send returns; low throughout before that
   task automatic wait_cts(output int unsigned k);
      k = 0;
      do begin
         @(posedge core_clk_i);
         #1;
         k++;
      end while (cts_o !== 1'b1 && k < 3000);
   endtask

   task automatic move(input cmd_t c, input op_state_t t, input op_state_t n,
                       input int unsigned exp_n);
      int unsigned k;
      host.xact(1'b1, c, t, n);
      wait_cts(k);
      chk_num("move cycles", exp_n, k); // cts timing
      chk_st("move state", t, state_o); // target
   endtask

   task automatic done_to(input op_state_t exp);
      @(posedge core_clk_i);
      op_done_i <= 1'b1;
      @(posedge core_clk_i);
      op_done_i <= 1'b0;
      #1;
      chk_st("after done", exp, state_o); // return
   endtask

   task automatic pulse_irq();
      @(posedge core_clk_i);
      irq_event_i <= 1'b1;
      @(posedge core_clk_i);
      irq_event_i <= 1'b0;
   endtask

   task automatic t_power_up();
      int unsigned k;
      tick(1);
      chk_st("por entry", ST_POR, state_o); // restart
      chk_bit("cts in por", 1'b0, cts_o); // busy
      wait_cts(k);
      chk_num("por cycles", POR, k); // length
      chk_st("after por", ST_STANDBY, state_o); // standby
      chk_bit("irq idle", 1'b1, irq_n_o); // idle
      chk_bit("retained", 1'b1, ret_o); // kept
      chk_bit("min current", 1'b1, minc_o); // idle
   endtask

   task automatic t_wake_boot();
      host.xact(1'b1, CMD_START_TX, ST_TX, ST_READY);
      #1;
      chk_bit("unbooted", 1'b1, refused_o); // refused
      chk_st("woken", ST_SPI_ACTIVE, state_o); // wake
      chk_bit("boot osc", 1'b1, bosc_o); // osc on
      host.xact(1'b1, CMD_BOOT, ST_READY, ST_READY); // boot
      tick(1);
      chk_bit("booted", 1'b1, booted_o); // boot
      tick(60);
      chk_st("spi hold", ST_SPI_ACTIVE, state_o); // stays
   endtask

   task automatic t_low_power();
      move(CMD_CHANGE_STATE, ST_STANDBY, ST_READY, 1); // back
      chk_bit("timer off", 1'b0, wut_o); // disabled
      move(CMD_CHANGE_STATE, ST_SLEEP, ST_READY, 1); // sleep
      chk_bit("timer on", 1'b1, wut_o); // timer
      host.xact(1'b0, CMD_BOOT, ST_READY, ST_READY);
      #1;
      chk_st("sleep wake", ST_SPI_ACTIVE, state_o); // wake
      tick(20);
      chk_st("spi hold", ST_SPI_ACTIVE, state_o); // holds
      move(CMD_CHANGE_STATE, ST_READY, ST_READY, 1); // change
   endtask

   task automatic t_timing();
      move(CMD_START_TX, ST_TX, ST_STANDBY, RDY); // ready
      chk_bit("xtal on", 1'b1, xosc_o); // radio on
      move(CMD_START_RX, ST_RX, ST_STANDBY, TRN); // turn
      zero_if_i <= 1'b1;
      move(CMD_START_TX, ST_TX, ST_STANDBY, ZIF); // zero if
      zero_if_i <= 1'b0;
      done_to(ST_STANDBY); // next state
      move(CMD_START_RX, ST_RX, ST_READY, SBY); // standby
      done_to(ST_READY); // next state
      move(CMD_CHANGE_STATE, ST_TX_TUNE, ST_READY, RDY); // tune
      move(CMD_START_TX, ST_TX, ST_READY, TXT); // tx tune
      done_to(ST_READY); // return
      move(CMD_CHANGE_STATE, ST_RX_TUNE, ST_READY, RDY); // tune
      move(CMD_START_RX, ST_RX, ST_READY, RXT); // rx tune
      done_to(ST_READY); // return
      move(CMD_CHANGE_STATE, ST_SPI_ACTIVE, ST_READY, 1); // change
      move(CMD_START_TX, ST_TX, ST_SLEEP, SPI); // spi
      done_to(ST_SLEEP); // sleep
   endtask

   task automatic t_busy();
      int unsigned k;
      move(CMD_CHANGE_STATE, ST_READY, ST_READY, 1); // change
      host.xact(1'b1, CMD_START_RX, ST_RX, ST_READY);
      host.xact(1'b1, CMD_CHANGE_STATE, ST_READY, ST_READY);
      #1;
      chk_bit("busy refuse", 1'b1, refused_o); // refused
      wait_cts(k);
      chk_st("busy target", ST_RX, state_o); // kept on
      host.xact(1'b1, CMD_CHANGE_STATE, ST_SHUTDOWN, ST_READY);
      #1;
      chk_bit("cmd to off", 1'b1, refused_o); // pin only
      chk_st("still rx", ST_RX, state_o); // unchanged
      done_to(ST_READY); // return
   endtask

   task automatic t_irq();
      move(CMD_CHANGE_STATE, ST_STANDBY, ST_READY, 1); // back
      pulse_irq();
      #1;
      chk_bit("irq out", 1'b0, irq_n_o); // raised
      chk_bit("min current", 1'b0, minc_o); // pending
      host.read_status();
      #1;
      chk_bit("irq cleared", 1'b1, irq_n_o); // cleared
      chk_bit("min current", 1'b1, minc_o); // lowest
      fork
         pulse_irq();
         host.read_status();
      join
      #1;
      chk_bit("irq wins", 1'b0, irq_n_o); // same cycle
      host.read_status();
      #1;
      chk_bit("irq cleared", 1'b1, irq_n_o); // cleared
   endtask

   task automatic t_shutdown();
      int unsigned k;
      host.sdn_on();
      tick(1);
      chk_st("off", ST_SHUTDOWN, state_o); // pin
      chk_bit("contents", 1'b0, ret_o); // lost
      chk_bit("boot lost", 1'b0, booted_o); // lost
      host.xact(1'b1, CMD_BOOT, ST_READY, ST_READY);
      #1;
      chk_bit("ignored", 1'b0, refused_o); // no access
      tick(1);
      chk_bit("not booted", 1'b0, booted_o); // no access
      chk_st("still off", ST_SHUTDOWN, state_o); // no wake
      host.sdn_off();
      tick(1);
      chk_st("restart", ST_POR, state_o); // restart
      wait_cts(k);
      chk_num("por cycles", POR, k); // length
      chk_bit("needs boot", 1'b0, booted_o); // boot
   endtask

   initial begin
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      t_power_up();
      t_wake_boot();
      t_low_power();
      t_timing();
      t_busy();
      t_irq();
      t_shutdown();
      tally_and_finish();
   end
endmodule // tb
